// [verilog/aop_defs.svh]
`ifndef AOP_DEFS_SVH
`define AOP_DEFS_SVH

// ------------------------------------------------------------
// clock and serial clock timing
// ------------------------------------------------------------
`define AOP_CLK_PERIOD_NS   20
`define AOP_SCLK_MIN_NS_0   25
`define AOP_SCLK_MIN_NS_1   50
`define AOP_SCLK_MIN_NS_2   100
`define AOP_SCLK_MIN_NS_3   200
// least periods round up to whole clock cycles
`define AOP_SCLK_CYC_0 ((`AOP_SCLK_MIN_NS_0 + `AOP_CLK_PERIOD_NS - 1) / `AOP_CLK_PERIOD_NS)
`define AOP_SCLK_CYC_1 ((`AOP_SCLK_MIN_NS_1 + `AOP_CLK_PERIOD_NS - 1) / `AOP_CLK_PERIOD_NS)
`define AOP_SCLK_CYC_2 ((`AOP_SCLK_MIN_NS_2 + `AOP_CLK_PERIOD_NS - 1) / `AOP_CLK_PERIOD_NS)
`define AOP_SCLK_CYC_3 ((`AOP_SCLK_MIN_NS_3 + `AOP_CLK_PERIOD_NS - 1) / `AOP_CLK_PERIOD_NS)

// ------------------------------------------------------------
// data bus pin positions
// ------------------------------------------------------------
`define AOP_D_RES0_BIT      0
`define AOP_D_RES1_BIT      1
`define AOP_D_DIV_LSB       2
`define AOP_D_DIV_MSB       3
`define AOP_D_CLKSRC_BIT    4
`define AOP_D_RDTIME_BIT    7
`define AOP_D_SERIAL_RESULT_OUT_BIT     8
`define AOP_LOW_BYTE_MSB    7
`define AOP_HIGH_BYTE_LSB   8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define AOP_RST_WORD        16'h0000
`define AOP_RST_OE          16'h0000
`define AOP_RST_BITS        5'h00
`define AOP_RST_CNT         4'h0

`endif

// [verilog/aop_pkg.sv]
`default_nettype none

package aop_pkg;

   // ------------------------------------------------------------
   // serial shifter states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      AOP_SER_IDLE  = 2'b01,
      AOP_SER_SHIFT = 2'b10
   } aop_ser_state_e;

   typedef logic [1:0] aop_div_code_t;
   typedef logic [3:0] aop_div_cnt_t;

endpackage

`default_nettype wire

// [verilog/aop_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module aop_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             in_valid_in,
   output var  logic             in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output var  logic             out_valid_out,
   input  wire logic             out_ready_in,
   output var  logic [WIDTH-1:0] out_data_out
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic [CW-1:0]    next_count;
   logic             push;
   logic             pop;

   // ------------------------------------------------------------
   // handshakes
   // ------------------------------------------------------------
   always_comb begin
      push = in_valid_in & in_ready_out;
      pop  = out_valid_out & out_ready_in;
      next_count = count;
      if (push & ~pop) begin
         next_count = count + CW'(1);
      end else if (pop & ~push) begin
         next_count = count - CW'(1);
      end
   end

   assign out_valid_out = (count != '0);
   assign out_data_out  = mem[rd_ptr];

   // ------------------------------------------------------------
   // storage and pointers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
         end
      end
   end

   // ready is registered so it never depends on the consumer combinationally
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count        <= '0;
         in_ready_out <= 1'b0;
      end else begin
         count        <= next_count;
         in_ready_out <= (next_count != CW'(DEPTH));
      end
   end

endmodule

`default_nettype wire

// [verilog/aop_port.sv]
// Function
// - byte order select low puts the low result byte on lines 7..0 and the high byte on 15..8, high swaps them.
// - coding select high gives straight binary, low inverts the msb to give twos complement.
// - port type select low enables the parallel bus, high enables the serial port on a subset of the bus pins.
// - lines 0 and 1 carry result bits 0 and 1 in parallel mode and float in serial mode.
// - in parallel mode lines 2 and 3 carry result bits 2 and 3.
// - in serial master read-after-convert mode lines 2 and 3 are a divider code input that slows the serial clock.
// - in every other serial mode lines 2 and 3 float.
// - divider codes 0 to 3 select least serial clock periods of 25, 50, 100 and 200 ns.
// - clock source select low drives the internal serial clock out, high follows an external serial clock.
// - with the internal clock, read timing select high shifts during conversion, low only after conversion.
// - the serial result leaves msb first from an internal shift register.
`timescale 1ns/1ps
`default_nettype none
`include "aop_defs.svh"

module aop_port #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             CLK_IN,
   input  wire logic             SYS_RST_IN,
   input  wire logic             BYTE_ORDER_SELECT_IN,
   input  wire logic             OUTPUT_CODING_SELECT_IN,
   input  wire logic             PORT_TYPE_SELECT_IN,
   input  wire logic [WIDTH-1:0] RESULT_IN,
   input  wire logic             RESULT_VALID_IN,
   output var  logic             RESULT_READY_OUT,
   input  wire logic             CONVERTING_IN,
   input  wire logic [15:0]      D_IN,
   output var  logic [15:0]      D_OUT,
   output var  logic [15:0]      D_OE_OUT,
   input  wire logic             SCLK_IN,
   output var  logic             SCLK_OUT,
   output var  logic             SCLK_OE_OUT,
   output var  logic             SERIAL_BUSY_OUT
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] code_word(input logic [15:0] raw,
                                             input logic        straight);
      logic [15:0] w;
      w = raw;
      w[15] = straight ? raw[15] : ~raw[15];
      return w;
   endfunction

   function automatic aop_pkg::aop_div_cnt_t div_cycles(input aop_pkg::aop_div_code_t code);
      aop_pkg::aop_div_cnt_t c;
      case (code)
         2'h0: c = 4'(`AOP_SCLK_CYC_0);
         2'h1: c = 4'(`AOP_SCLK_CYC_1);
         2'h2: c = 4'(`AOP_SCLK_CYC_2);
         2'h3: c = 4'(`AOP_SCLK_CYC_3);
         default: c = 4'(`AOP_SCLK_CYC_0);
      endcase
      return c;
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic                   fifo_valid;
   logic                   fifo_ready;
   logic [WIDTH-1:0]       fifo_data;
   logic                   fifo_in_ready;
   aop_pkg::aop_ser_state_e state;
   aop_pkg::aop_ser_state_e next_state;
   logic [15:0]            raw_word;
   logic [15:0]            shift_reg;
   logic [15:0]            next_shift;
   logic [4:0]             bits_left;
   aop_pkg::aop_div_cnt_t  div_cnt;
   aop_pkg::aop_div_cnt_t  period;
   aop_pkg::aop_div_cnt_t  half;
   aop_pkg::aop_div_code_t div_code;
   logic                   sclk_prev;
   logic                   serial_mode;
   logic                   ext_clk;
   logic                   rd_during;
   logic                   master_rac;
   logic                   start_ok;
   logic                   pop;
   logic                   ext_rise;
   logic                   shift_tick;
   logic [15:0]            par_word;

   // ------------------------------------------------------------
   // result buffer
   // ------------------------------------------------------------
   aop_fifo #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH)
   ) i_aop_fifo (
      .clk_in        (CLK_IN),
      .rst_in        (SYS_RST_IN),
      .in_valid_in   (RESULT_VALID_IN),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (RESULT_IN),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_ready),
      .out_data_out  (fifo_data)
   );

   assign RESULT_READY_OUT = fifo_in_ready;

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   always_comb begin
      serial_mode = PORT_TYPE_SELECT_IN;
      ext_clk     = D_IN[`AOP_D_CLKSRC_BIT];
      rd_during   = D_IN[`AOP_D_RDTIME_BIT];
      master_rac  = serial_mode & ~ext_clk & ~rd_during;
      // the divider code is only decoded in master read-after-convert, other modes count with code 0
      div_code    = master_rac ? D_IN[`AOP_D_DIV_MSB:`AOP_D_DIV_LSB] : 2'h0;
      period      = div_cycles(div_code);
      half        = period >> 1;
      if (ext_clk) begin
         start_ok = 1'b1;
      end else begin
         start_ok = rd_during ? CONVERTING_IN : ~CONVERTING_IN;
      end
      if (serial_mode) begin
         fifo_ready = (state == aop_pkg::AOP_SER_IDLE) & start_ok;
      end else begin
         fifo_ready = 1'b1;
      end
      pop        = fifo_valid & fifo_ready;
      ext_rise   = SCLK_IN & ~sclk_prev;
      if (state != aop_pkg::AOP_SER_SHIFT) begin
         shift_tick = 1'b0;
      end else if (ext_clk) begin
         shift_tick = ext_rise;
      end else begin
         shift_tick = (div_cnt == period - 4'h1);
      end
   end

   // ------------------------------------------------------------
   // serial sequencing
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         aop_pkg::AOP_SER_IDLE: begin
            if (serial_mode & pop) begin
               next_state = aop_pkg::AOP_SER_SHIFT;
            end
         end
         aop_pkg::AOP_SER_SHIFT: begin
            if (~serial_mode) begin
               next_state = aop_pkg::AOP_SER_IDLE;
            end else if (shift_tick & (bits_left == 5'h01)) begin
               next_state = aop_pkg::AOP_SER_IDLE;
            end
         end
         default: next_state = aop_pkg::AOP_SER_IDLE;
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         state <= aop_pkg::AOP_SER_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // shift register
   // ------------------------------------------------------------
   always_comb begin
      next_shift = shift_reg;
      if (serial_mode & pop) begin
         next_shift = code_word(fifo_data, OUTPUT_CODING_SELECT_IN);
      end else if (shift_tick) begin
         next_shift = {shift_reg[14:0], 1'b0};
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         shift_reg <= `AOP_RST_WORD;
      end else begin
         shift_reg <= next_shift;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         bits_left <= `AOP_RST_BITS;
      end else if (serial_mode & pop) begin
         bits_left <= 5'h10;
      end else if (shift_tick) begin
         bits_left <= bits_left - 5'h01;
      end
   end

   // ------------------------------------------------------------
   // internal serial clock
   // ------------------------------------------------------------
   // data changes at load or with the falling edge, so it is stable at each rising edge
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         div_cnt <= `AOP_RST_CNT;
      end else if ((state == aop_pkg::AOP_SER_SHIFT) & ~ext_clk) begin
         div_cnt <= (div_cnt == period - 4'h1) ? 4'h0 : div_cnt + 4'h1;
      end else begin
         div_cnt <= `AOP_RST_CNT;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         SCLK_OUT <= 1'b0;
      end else if ((next_state == aop_pkg::AOP_SER_SHIFT) & ~ext_clk & (state == aop_pkg::AOP_SER_SHIFT)) begin
         if (div_cnt == half - 4'h1) begin
            SCLK_OUT <= 1'b1;
         end else if (div_cnt == period - 4'h1) begin
            SCLK_OUT <= 1'b0;
         end
      end else begin
         SCLK_OUT <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         SCLK_OE_OUT <= 1'b0;
      end else begin
         SCLK_OE_OUT <= serial_mode & ~ext_clk;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= SCLK_IN;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         SERIAL_BUSY_OUT <= 1'b0;
      end else begin
         SERIAL_BUSY_OUT <= (next_state == aop_pkg::AOP_SER_SHIFT);
      end
   end

   // ------------------------------------------------------------
   // parallel word
   // ------------------------------------------------------------
   // selects are applied live, so they must not move mid-read
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         raw_word <= `AOP_RST_WORD;
      end else if (~serial_mode & pop) begin
         raw_word <= fifo_data;
      end
   end

   always_comb begin
      par_word = code_word(raw_word, OUTPUT_CODING_SELECT_IN);
      if (BYTE_ORDER_SELECT_IN) begin
         par_word = {par_word[`AOP_LOW_BYTE_MSB:0], par_word[15:`AOP_HIGH_BYTE_LSB]};
      end
   end

   // ------------------------------------------------------------
   // data bus pins
   // ------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         D_OUT    <= `AOP_RST_WORD;
         D_OE_OUT <= `AOP_RST_OE;
      end else if (~serial_mode) begin
         D_OUT    <= par_word;
         D_OE_OUT <= 16'hffff;
      end else begin
         D_OUT                    <= `AOP_RST_WORD;
         D_OUT[`AOP_D_SERIAL_RESULT_OUT_BIT]  <= next_shift[15];
         // lines 0..3 float: result bits 0,1 off, 2,3 are inputs or idle
         D_OE_OUT                 <= `AOP_RST_OE;
         D_OE_OUT[`AOP_D_SERIAL_RESULT_OUT_BIT] <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// [verif/aop_port_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module aop_port_chk #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic        CLK_IN,
   input wire logic        SYS_RST_IN,
   input wire logic        PORT_TYPE_SELECT_IN,
   input wire logic        CONVERTING_IN,
   input wire logic [15:0] D_IN,
   input wire logic [15:0] D_OUT,
   input wire logic [15:0] D_OE_OUT,
   input wire logic        SCLK_IN,
   input wire logic        SCLK_OUT,
   input wire logic        SCLK_OE_OUT,
   input wire logic        SERIAL_BUSY_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   wire logic ser = PORT_TYPE_SELECT_IN;
   property p_oe_par; !ser |=> D_OE_OUT == 16'hffff; endproperty
   a_oe_par: assert property (p_oe_par) else $error("bus not driven in parallel mode");
   property p_oe_ser; ser |=> D_OE_OUT == 16'h0100; endproperty
   a_oe_ser: assert property (p_oe_ser) else $error("wrong pins driven in serial mode");
   property p_clk_oe; ser && !D_IN[4] |=> SCLK_OE_OUT; endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("internal serial clock not driven");
   property p_busy_par; !ser [*2] |-> !SERIAL_BUSY_OUT; endproperty
   a_busy_par: assert property (p_busy_par) else $error("shifting in parallel mode");
   // a forced code 0 when shifting during conversion keeps the fastest clock
   property p_clk_fast;
      $rose(SCLK_OUT) && (D_IN[3:2] == 2'h0 || D_IN[7]) |=> !SCLK_OUT;
   endproperty
   a_clk_fast: assert property (p_clk_fast) else $error("code 0 clock high too long");
   property p_clk_mid; $rose(SCLK_OUT) && D_IN[3:2] == 2'h1 && !D_IN[7] |-> SCLK_OUT [*2] ##1 !SCLK_OUT; endproperty
   a_clk_mid: assert property (p_clk_mid) else $error("code 1 clock high time wrong");
   property p_clk_slow; $rose(SCLK_OUT) && D_IN[3:2] == 2'h3 && !D_IN[7] |-> SCLK_OUT [*5] ##1 !SCLK_OUT; endproperty
   a_clk_slow: assert property (p_clk_slow) else $error("code 3 clock high time wrong");
   property p_rd_time; $rose(SERIAL_BUSY_OUT) && !D_IN[4] |-> $past(CONVERTING_IN) == D_IN[7]; endproperty
   a_rd_time: assert property (p_rd_time) else $error("shift started at wrong time");
   property p_ext_hold;
      ser && D_IN[4] && SERIAL_BUSY_OUT && !(SCLK_IN && !$past(SCLK_IN)) |=> $stable(D_OUT[8]);
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("serial bit moved without clock");
   c_ext: cover property ($rose(SERIAL_BUSY_OUT) && D_IN[4]);
   c_slow: cover property ($rose(SCLK_OUT) && D_IN[3:2] == 2'h3 && !D_IN[7]);
   c_abort: cover property (SERIAL_BUSY_OUT && ser ##1 !ser);
endmodule

bind aop_port aop_port_chk #(.WIDTH(WIDTH), .DEPTH(DEPTH)) i_aop_port_chk (.CLK_IN(CLK_IN),
   .SYS_RST_IN(SYS_RST_IN), .PORT_TYPE_SELECT_IN(PORT_TYPE_SELECT_IN), .CONVERTING_IN(CONVERTING_IN),
   .D_IN(D_IN), .D_OUT(D_OUT), .D_OE_OUT(D_OE_OUT), .SCLK_IN(SCLK_IN), .SCLK_OUT(SCLK_OUT),
   .SCLK_OE_OUT(SCLK_OE_OUT), .SERIAL_BUSY_OUT(SERIAL_BUSY_OUT));
`default_nettype wire

// [verif/aop_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// host reading results
// ----
module aop_host (
   input  wire logic        clk_in,
   input  wire logic        ser_in,
   input  wire logic        ext_in,
   input  wire logic        rd_in,
   input  wire logic [1:0]  div_in,
   input  wire logic [15:0] d_out_in,
   input  wire logic [15:0] d_oe_in,
   input  wire logic        busy_in,
   input  wire logic        sclk_dev_in,
   output var  logic [15:0] d_in_out,
   output var  logic        sclk_out
);
   logic        flt;
   logic [15:0] hd;
   logic [15:0] ho;
   initial flt = 1'b0;
   initial sclk_out = 1'b0;
   // undriven lines toggle so a stale value is never mistaken for data
   always @(posedge clk_in) flt <= ~flt;
   always_comb begin
      hd = {8'h00, rd_in, 2'b00, ext_in, div_in, 2'b00};
      ho = ser_in ? 16'h0090 : 16'h0000;
      if (ser_in && !ext_in && !rd_in) ho[3:2] = 2'b11;
      for (int i = 0; i < 16; i++) d_in_out[i] = d_oe_in[i] ? d_out_in[i] : (ho[i] ? hd[i] : flt);
   end
   task automatic read_word(output logic [15:0] w);
      int n;
      n = 0;
      while (busy_in !== 1'b1 && n < 500) begin
         @(negedge clk_in);
         n++;
      end
      for (int i = 15; i >= 0; i--) begin
         if (ext_in) begin
            repeat (3) @(negedge clk_in);
            w[i] = d_out_in[8];
            sclk_out = 1'b1;
            repeat (3) @(negedge clk_in);
            sclk_out = 1'b0;
         end else begin
            @(posedge sclk_dev_in);
            #1 w[i] = d_out_in[8];
         end
      end
      // internal clock: let the last period run out so the next request meets an idle shifter on a falling edge
      if (!ext_in) begin
         while (busy_in !== 1'b0 && n < 1000) begin
            @(negedge clk_in);
            n++;
         end
      end
   endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rst, swap, straight, ser, valid, conv, ext, rd;
   logic        ready, sclk_in, sclk_out, sclk_oe, busy;
   logic [1:0]  div;
   logic [15:0] res, d_in, d_out, d_oe, w;
   int          fail_count, comparisons, cyc;
   initial clk = 1'b0;
   always #10 clk = ~clk;
   aop_port #(.WIDTH(16), .DEPTH(4)) i_aop_port (.CLK_IN(clk), .SYS_RST_IN(rst), .BYTE_ORDER_SELECT_IN(swap),
      .OUTPUT_CODING_SELECT_IN(straight), .PORT_TYPE_SELECT_IN(ser), .RESULT_IN(res), .RESULT_VALID_IN(valid),
      .RESULT_READY_OUT(ready), .CONVERTING_IN(conv), .D_IN(d_in), .D_OUT(d_out), .D_OE_OUT(d_oe),
      .SCLK_IN(sclk_in), .SCLK_OUT(sclk_out), .SCLK_OE_OUT(sclk_oe), .SERIAL_BUSY_OUT(busy));
   aop_host i_aop_host (.clk_in(clk), .ser_in(ser), .ext_in(ext), .rd_in(rd), .div_in(div), .d_out_in(d_out),
      .d_oe_in(d_oe), .busy_in(busy), .sclk_dev_in(sclk_out), .d_in_out(d_in), .sclk_out(sclk_in));
   // ----
   // helpers
   // ----
   function automatic logic [15:0] fmt(input logic [15:0] v, input logic sw, input logic sb);
      logic [15:0] c;
      c = sb ? v : {~v[15], v[14:0]};
      return sw ? {c[7:0], c[15:8]} : c;
   endfunction
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   // valid stays up on return so back-to-back words need no gap
   task automatic push(input logic [15:0] v);
      res = v;
      valid = 1'b1;
      while (ready !== 1'b1) @(negedge clk);
      @(negedge clk);
   endtask
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end
   // ----
   // tests
   // ----
   initial begin
      {rst, straight} = 2'b11;
      {swap, ser, valid, conv, ext, rd, div, res} = '0;
      {fail_count, comparisons, cyc} = '0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      push(16'h8a53);
      valid = 1'b0;
      for (int k = 0; k < 4; k++) begin
         {straight, swap} = k[1:0];
         repeat (3) @(negedge clk);
         check("parallel word", d_out, fmt(16'h8a53, k[0], k[1]));
         check("parallel enable", d_oe, 16'hffff);
      end
      $display("test parallel done");
      {ser, swap, straight} = 3'b110;
      for (int k = 0; k < 4; k++) begin
         div = k[1:0];
         push(16'hc3a5 ^ k[15:0]);
         valid = 1'b0;
         i_aop_host.read_word(w);
         check("serial word", w, fmt(16'hc3a5 ^ k[15:0], 1'b0, 1'b0));
         check("serial enable", d_oe, 16'h0100);
         check("clock enable", {15'h0000, sclk_oe}, 16'h0001);
      end
      {rd, div} = 3'b111;
      push(16'h0001);
      valid = 1'b0;
      repeat (20) @(negedge clk);
      check("busy before conversion", {15'h0000, busy}, 16'h0000);
      conv = 1'b1;
      i_aop_host.read_word(w);
      check("serial word", w, 16'h8001);
      {conv, rd, div} = '0;
      $display("test internal clock done");
      {ext, straight} = 2'b11;
      for (int k = 0; k < 5; k++) push(16'h7e00 + k[15:0]);
      valid = 1'b0;
      repeat (3) @(negedge clk);
      check("ready when full", {15'h0000, ready}, 16'h0000);
      check("clock enable", {15'h0000, sclk_oe}, 16'h0000);
      for (int k = 0; k < 5; k++) begin
         repeat (4) @(negedge clk);
         i_aop_host.read_word(w);
         check("external word", w, 16'h7e00 + k[15:0]);
      end
      repeat (3) @(negedge clk);
      check("ready when empty", {15'h0000, ready}, 16'h0001);
      $display("test external clock done");
      push(16'h5555);
      valid = 1'b0;
      repeat (4) @(negedge clk);
      ser = 1'b0;
      repeat (3) @(negedge clk);
      check("busy after abort", {15'h0000, busy}, 16'h0000);
      check("parallel enable", d_oe, 16'hffff);
      $display("test abort done");
      close_out();
   end
endmodule
`default_nettype wire
